// [core/sramc_ctrl.sv]
// Purpose: Host-side controller that drives the 512K x 32 SRAM module pins.
// Assumes: Pin inputs are synchronous to core_clk; slowest speed grade.
// Notes:   One access at a time; a read and a write never overlap.
`timescale 1ns/1ps
`default_nettype none

module sramc_ctrl #(
    parameter int unsigned RECOVERY_CYC = sramc_pkg::T_R_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire sramc_pkg::sramc_req_t req,
    output logic req_ready,
    output logic resp_valid,
    output logic [31:0] resp_rdata,
    input wire logic retention_req,
    output logic retention_active,
    output sramc_pkg::sramc_pins_t pins,
    output logic [31:0] data_out,
    output logic data_oe_n,
    input wire logic [31:0] data_in
);

    // ------------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_ADDR,
        ST_RD_WAIT,
        ST_TURN,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_TAIL,
        ST_STBY,
        ST_RECOVER
    } sramc_state_t;

    sramc_state_t state_q, state_d;
    logic [sramc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    sramc_pkg::sramc_req_t cur_q, cur_d;
    sramc_pkg::sramc_pins_t pins_q, pins_d;
    logic [31:0] dout_q, dout_d;
    logic doe_n_q, doe_n_d;
    logic ready_q, rvalid_q, rvalid_d, ret_q;
    logic [31:0] rdata_q, rdata_d;

    // ------------------------------------------------------------------
    // Lane decode
    // ------------------------------------------------------------------
    wire [3:0] cur_mask;
    wire [31:0] cur_wdata;
    wire [31:0] cur_rdata;

    // Lane decode works on the latched request so pins stay steady.
    sramc_lane_map u_lane_map (
        .size(cur_q.size),
        .lsb(cur_q.addr[1:0]),
        .wdata(cur_q.wdata),
        .raw_rdata(data_in),
        .lane_mask(cur_mask),
        .lane_wdata(cur_wdata),
        .aligned_rdata(cur_rdata)
    );

    // Count reloads, each one less than the number of cycles spent. The
    // strobe falls a cycle after its load, so its reload is the full width.
    localparam logic [sramc_pkg::CNT_W-1:0] RC_LOAD =
        sramc_pkg::CNT_W'(sramc_pkg::RC_CYC - 1);
    localparam logic [sramc_pkg::CNT_W-1:0] WP_LOAD =
        sramc_pkg::CNT_W'(sramc_pkg::WP_CYC);
    localparam logic [sramc_pkg::CNT_W-1:0] TAIL_LOAD =
        sramc_pkg::CNT_W'(sramc_pkg::WR_TAIL_CYC - 1);
    localparam logic [sramc_pkg::CNT_W-1:0] TURN_LOAD =
        sramc_pkg::CNT_W'(sramc_pkg::TURN_CYC - 1);
    wire [sramc_pkg::CNT_W-1:0] rec_load =
        sramc_pkg::CNT_W'(RECOVERY_CYC - 1);

    wire cnt_done = (cnt_q == '0);
    wire [sramc_pkg::CNT_W-1:0] cnt_dec = cnt_q - 1'b1;
    wire take = req_valid && ready_q && (state_q == ST_IDLE);
    wire [18:0] req_word = req.addr[20:2];
    wire [3:0] cur_sel_n = ~cur_mask;

    // ------------------------------------------------------------------
    // Next-state and pin decode
    // ------------------------------------------------------------------
    // Pins are computed here and registered so every pin is a flop output.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cur_d = cur_q;
        pins_d = pins_q;
        dout_d = dout_q;
        doe_n_d = doe_n_q;
        rvalid_d = 1'b0;
        rdata_d = rdata_q;
        unique case (state_q)
            ST_IDLE: begin
                pins_d.lane_select_n = sramc_pkg::LANES_ALL;
                pins_d.lane_write_strobe_n = sramc_pkg::LANES_ALL;
                pins_d.output_enable_n = 1'b1;
                doe_n_d = 1'b1;
                if (take) begin
                    // A promised request wins over a retention request.
                    cur_d = req;
                    pins_d.word_address = req_word;
                    state_d = req.write ? ST_WR_SETUP : ST_RD_ADDR;
                end else if (retention_req) begin
                    state_d = ST_STBY;
                end
            end
            ST_RD_ADDR: begin
                // Address has stood one cycle; select and enable fall now.
                pins_d.lane_select_n = cur_sel_n;
                pins_d.lane_write_strobe_n = sramc_pkg::LANES_ALL;
                pins_d.output_enable_n = 1'b0;
                cnt_d = RC_LOAD;
                state_d = ST_RD_WAIT;
            end
            ST_RD_WAIT: begin
                // Wait the full read cycle before sampling the lines.
                if (cnt_done) begin
                    rdata_d = cur_rdata;
                    rvalid_d = 1'b1;
                    pins_d.lane_select_n = sramc_pkg::LANES_ALL;
                    pins_d.output_enable_n = 1'b1;
                    cnt_d = TURN_LOAD;
                    state_d = ST_TURN;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_TURN: begin
                // Let the module release the data lines before reuse.
                if (cnt_done) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_WR_SETUP: begin
                // Select falls before the strobe, data is driven from here.
                pins_d.lane_select_n = cur_sel_n;
                pins_d.output_enable_n = 1'b1;
                dout_d = cur_wdata;
                doe_n_d = 1'b0;
                cnt_d = WP_LOAD;
                state_d = ST_WR_PULSE;
            end
            ST_WR_PULSE: begin
                // Strobe only the selected lanes so others keep their bytes.
                pins_d.lane_write_strobe_n = cur_sel_n;
                if (cnt_done) begin
                    pins_d.lane_write_strobe_n = sramc_pkg::LANES_ALL;
                    cnt_d = TAIL_LOAD;
                    state_d = ST_WR_TAIL;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_WR_TAIL: begin
                // Strobe is high; drop select and data, pad to the cycle time.
                pins_d.lane_select_n = sramc_pkg::LANES_ALL;
                doe_n_d = 1'b1;
                if (cnt_done) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_STBY: begin
                // All selects stay high through retention.
                pins_d.lane_select_n = sramc_pkg::LANES_ALL;
                if (!retention_req) begin
                    cnt_d = rec_load;
                    state_d = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // No access until the recovery time has passed.
                if (cnt_done) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Ready only in idle, and not while a retention request is pending.
    wire ready_d = (state_d == ST_IDLE) && !(retention_req && !take);
    wire ret_d = (state_d == ST_STBY) || (state_d == ST_RECOVER);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Control state and pins.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            pins_q <= sramc_pkg::PINS_IDLE;
            doe_n_q <= 1'b1;
            ready_q <= 1'b0;
            ret_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pins_q <= pins_d;
            doe_n_q <= doe_n_d;
            ready_q <= ready_d;
            ret_q <= ret_d;
        end
    end

    // Datapath registers and the response strobe.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur_q <= '0;
            dout_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            cur_q <= cur_d;
            dout_q <= dout_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Outputs straight from flops.
    assign pins = pins_q;
    assign data_out = dout_q;
    assign data_oe_n = doe_n_q;
    assign req_ready = ready_q;
    assign resp_valid = rvalid_q;
    assign resp_rdata = rdata_q;
    assign retention_active = ret_q;

endmodule : sramc_ctrl

`default_nettype wire

// [core/sramc_lane_map.sv]
// Purpose: Maps an access width and byte address onto SRAM byte lanes.
// Assumes: Halfwords and words are naturally aligned; low bits ignored.
// Notes:   Purely combinational; the caller registers every result.
`timescale 1ns/1ps
`default_nettype none

module sramc_lane_map (
    input wire sramc_pkg::sramc_size_t size,
    input wire logic [1:0] lsb,
    input wire logic [31:0] wdata,
    input wire logic [31:0] raw_rdata,
    output logic [3:0] lane_mask,
    output logic [31:0] lane_wdata,
    output logic [31:0] aligned_rdata
);

    // Lane choice per width: all, a pair, or a single byte.
    wire [3:0] byte_mask = sramc_pkg::LANE_ONE << lsb;
    wire [3:0] half_mask = lsb[1] ? sramc_pkg::LANES_HIGH_PAIR
                                  : sramc_pkg::LANES_LOW_PAIR;
    assign lane_mask = (size == sramc_pkg::SZ_WORD) ? sramc_pkg::LANES_ALL :
                       (size == sramc_pkg::SZ_HALF) ? half_mask :
                       (size == sramc_pkg::SZ_BYTE) ? byte_mask :
                       sramc_pkg::LANES_NONE;

    // Byte and halfword write data is copied into every lane so the active ones carry it.
    assign lane_wdata = (size == sramc_pkg::SZ_WORD) ? wdata :
                        (size == sramc_pkg::SZ_HALF) ? {2{wdata[15:0]}} :
                        {4{wdata[7:0]}};

    // Read data is shifted down from the addressed lanes and zero filled.
    wire [31:0] half_rd = {16'h0000, lsb[1] ? raw_rdata[31:16]
                                            : raw_rdata[15:0]};
    wire [31:0] byte_rd = {24'h00_0000, raw_rdata[8*lsb +: 8]};
    assign aligned_rdata = (size == sramc_pkg::SZ_WORD) ? raw_rdata :
                           (size == sramc_pkg::SZ_HALF) ? half_rd :
                           byte_rd;

endmodule : sramc_lane_map

`default_nettype wire

// [include/sramc_pkg.sv]
// Purpose: Shared types and timing constants for the SRAM module controller.
// Assumes: 250 MHz core clock; slowest speed grade of the SRAM module.
// Notes:   All pin timing is counted in whole core clock cycles.
package sramc_pkg;

    // ------------------------------------------------------------------
    // Widths and lane layout
    // ------------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int BYTE_ADDR_W = 21;
    localparam logic [3:0] LANES_NONE = 4'h0;
    localparam logic [3:0] LANES_ALL = 4'hF;
    localparam logic [3:0] LANES_LOW_PAIR = 4'h3;
    localparam logic [3:0] LANES_HIGH_PAIR = 4'hC;
    localparam logic [3:0] LANE_ONE = 4'h1;

    // ------------------------------------------------------------------
    // Timing: figures in ns or ms, counts derived from the clock period
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_RC_NS = 55;
    localparam int T_WC_NS = 55;
    localparam int T_WP_NS = 15;
    localparam int T_DW_NS = 10;
    localparam int T_OHZ_NS = 10;
    localparam int T_R_MS = 5;
    localparam int RC_CYC = (T_RC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WC_CYC = (T_WC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DW_CYC = (T_DW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TURN_CYC =
        (T_OHZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_TAIL_CYC =
        (WC_CYC - WP_CYC - 1 > 0) ? WC_CYC - WP_CYC - 1 : 1;
    localparam longint T_R_CYC_L =
        (longint'(T_R_MS) * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_R_CYC = int'(T_R_CYC_L);
    localparam int CNT_W = 21;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_HALF,
        SZ_WORD
    } sramc_size_t;

    // One access request from the user side.
    typedef struct packed {
        logic write;
        sramc_size_t size;
        logic [BYTE_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sramc_req_t;

    // Control pins toward the SRAM module, all active low except address.
    typedef struct packed {
        logic [ADDR_W-1:0] word_address;
        logic [LANES-1:0] lane_select_n;
        logic [LANES-1:0] lane_write_strobe_n;
        logic output_enable_n;
    } sramc_pins_t;

    localparam sramc_pins_t PINS_IDLE = '{
        word_address: 19'h0_0000,
        lane_select_n: 4'hF,
        lane_write_strobe_n: 4'hF,
        output_enable_n: 1'h1
    };

endpackage : sramc_pkg

// [tb/sramc_ctrl_monitor.sv]
// Purpose: Checks pin timing of the SRAM module controller.
// Assumes: Bound to sramc_ctrl; one clock domain.
// Notes:   Counters hold run lengths of low control pins and of the recovery wait.
`timescale 1ns/1ps
`default_nettype none
module sramc_ctrl_monitor #(
    parameter int unsigned RECOVERY_CYC = sramc_pkg::T_R_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire sramc_pkg::sramc_req_t req,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic [31:0] resp_rdata,
    input wire logic retention_req,
    input wire logic retention_active,
    input wire sramc_pkg::sramc_pins_t pins,
    input wire logic [31:0] data_out,
    input wire logic data_oe_n,
    input wire logic [31:0] data_in
);
    localparam int READ_LOW_CYC = 14;
    localparam int STROBE_LOW_CYC = 4;
    logic [4:0] oe_cnt_q;
    logic [4:0] oe_cnt_d;
    logic [4:0] stb_cnt_q;
    logic [4:0] stb_cnt_d;
    logic [20:0] rec_cnt_q;
    logic [20:0] rec_cnt_d;
    wire logic [3:0] sel_n = pins.lane_select_n;
    wire logic [3:0] stb_n = pins.lane_write_strobe_n;
    // Pin run lengths saturate so they never wrap back to a small value; the recovery count does not.
    assign oe_cnt_d = pins.output_enable_n ? 5'h0 : oe_cnt_q + 5'(~&oe_cnt_q);
    assign stb_cnt_d = (stb_n == 4'hF) ? 5'h0 : stb_cnt_q + 5'(~&stb_cnt_q);
    assign rec_cnt_d = (retention_active && !retention_req) ?
        rec_cnt_q + 21'h1 : 21'h0;
    // Counter registers.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            oe_cnt_q <= 5'h0;
            stb_cnt_q <= 5'h0;
            rec_cnt_q <= 21'h0;
        end else begin
            oe_cnt_q <= oe_cnt_d;
            stb_cnt_q <= stb_cnt_d;
            rec_cnt_q <= rec_cnt_d;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_take_read;
        req_valid && req_ready && !req.write;
    endsequence
    sequence s_sel_fall;
        $past(sel_n) == 4'hF && sel_n != 4'hF;
    endsequence
    a_no_contention: assert property (!data_oe_n |-> pins.output_enable_n)
        else $error("data lines driven against module");
    a_read_no_strobe: assert property (!pins.output_enable_n |-> stb_n == 4'hF)
        else $error("strobe low during read");
    a_write_overlap: assert property ((~stb_n & sel_n) == 4'h0)
        else $error("strobe low on unselected lane");
    a_select_first: assert property ((~stb_n & $past(sel_n)) == 4'h0)
        else $error("strobe fell before select");
    a_address_first: assert property (s_sel_fall |-> $stable(pins.word_address))
        else $error("address moved as select fell");
    a_lane_group: assert property (sel_n inside {4'hF, 4'h0, 4'h3, 4'hC,
        4'hE, 4'hD, 4'hB, 4'h7}) else $error("bad lane grouping");
    a_read_latency: assert property (s_take_read |-> ##[16:17] resp_valid)
        else $error("read answer late");
    a_read_window: assert property ($rose(pins.output_enable_n)
        |-> oe_cnt_q >= READ_LOW_CYC) else $error("read window short");
    a_strobe_width: assert property ($rose(stb_n == 4'hF)
        |-> stb_cnt_q >= STROBE_LOW_CYC) else $error("strobe pulse short");
    a_recovery_wait: assert property ($fell(retention_active)
        |-> 32'(rec_cnt_q) + 1 >= RECOVERY_CYC) else $error("recovery short");
endmodule : sramc_ctrl_monitor
bind sramc_ctrl sramc_ctrl_monitor #(.RECOVERY_CYC(RECOVERY_CYC)) mon_i (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .retention_req(retention_req), .retention_active(retention_active),
    .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_in(data_in)
);
`default_nettype wire

// [tb/sramc_mem_model.sv]
// Purpose: Behavioural model of the four-lane SRAM module.
// Assumes: Pins change only just after core_clk edges.
// Notes:   Released data lines show a pattern that flips every cycle.
`timescale 1ns/1ps
`default_nettype none
module sramc_mem_model (
    input wire logic core_clk,
    input wire sramc_pkg::sramc_pins_t pins,
    input wire logic [31:0] data_out,
    input wire logic data_oe_n,
    output logic [31:0] data_in
);
    logic [31:0] mem [logic [18:0]];
    logic [31:0] rd_q = 32'h0;
    logic [31:0] pat_q = 32'h5A5A_A5A5;
    logic [3:0] rd_lane;
    logic [31:0] rd_mask;
    // A lane drives only when selected, enabled and not strobed.
    assign rd_lane = ~pins.lane_select_n & pins.lane_write_strobe_n &
        {4{~pins.output_enable_n}};
    assign rd_mask = {{8{rd_lane[3]}}, {8{rd_lane[2]}},
        {8{rd_lane[1]}}, {8{rd_lane[0]}}};
    assign data_in = !data_oe_n ? data_out :
        (rd_q & rd_mask) | (pat_q & ~rd_mask);
    // Each lane stores its byte while select and strobe are both low.
    always @(posedge core_clk) begin : store
        logic [31:0] w;
        w = mem.exists(pins.word_address) ? mem[pins.word_address] : 32'h0;
        for (int k = 0; k < 4; k++) begin
            if (!pins.lane_select_n[k] && !pins.lane_write_strobe_n[k]) begin
                w[8*k +: 8] = data_in[8*k +: 8];
            end
        end
        mem[pins.word_address] = w;
        rd_q <= w;
        pat_q <= ~pat_q;
    end
endmodule : sramc_mem_model
`default_nettype wire

// [tb/tb_async_sram_512k_x32_module.sv]
// Purpose: Self-checking bench for the SRAM module controller.
// Assumes: Short recovery count; memory model on the pins.
// Notes:   Ordinary accesses run from a table; standby and reset follow.
`timescale 1ns/1ps
`default_nettype none
module tb_async_sram_512k_x32_module;
    localparam int REC = 20;
    typedef struct packed {
        sramc_pkg::sramc_req_t r;
        logic [31:0] exp;
    } sramc_row_t;
    logic core_clk;
    logic rst;
    logic req_valid;
    sramc_pkg::sramc_req_t req;
    logic req_ready;
    logic resp_valid;
    logic [31:0] resp_rdata;
    logic retention_req;
    logic retention_active;
    sramc_pkg::sramc_pins_t pins;
    logic [31:0] data_out;
    logic data_oe_n;
    wire logic [31:0] data_in;
    sramc_row_t rows [11];
    int bad_count;
    int checks_done;
    int n;

    sramc_ctrl #(.RECOVERY_CYC(REC)) sramc_ctrl_i (
        .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_rdata(resp_rdata), .retention_req(retention_req),
        .retention_active(retention_active), .pins(pins),
        .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in)
    );
    sramc_mem_model sramc_mem_model_i (
        .core_clk(core_clk), .pins(pins), .data_out(data_out),
        .data_oe_n(data_oe_n), .data_in(data_in)
    );

    // Free-running 250 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    function automatic sramc_row_t mk(input logic w, input logic [1:0] s,
        input logic [20:0] a, input logic [31:0] d, input logic [31:0] e);
        return {w, s, a, d, e};
    endfunction : mk

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic give_up();
        bad_count++;
        $display("unexpected at %0t: wait ran out", $time);
        stop_test();
    endtask : give_up

    // Holds the request until taken, then checks any read answer.
    task automatic run(input sramc_row_t w);
        int k;
        req = w.r;
        req_valid = 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (req_ready !== 1'b1 && k < 100);
        if (req_ready !== 1'b1) give_up();
        #1;
        req_valid = 1'b0;
        if (!w.r.write) begin
            k = 0;
            do begin
                @(posedge core_clk);
                #1;
                k++;
            end while (resp_valid !== 1'b1 && k < 40);
            if (resp_valid !== 1'b1) give_up();
            chk(resp_rdata, w.exp);
        end else begin
            // Let an edge pass so valid never toggles twice in one step.
            @(posedge core_clk);
            #1;
        end
    endtask : run

    // Main sequence: reset, table, standby, second reset.
    initial begin
        bad_count = 0;
        checks_done = 0;
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        retention_req = 1'b0;
        rows = '{mk(1'h1, 2'h2, 21'h10, 32'h1122_3344, 32'h0),
            mk(1'h1, 2'h0, 21'h11, 32'h0000_00AB, 32'h0),
            mk(1'h0, 2'h2, 21'h10, 32'h0, 32'h1122_AB44),
            mk(1'h1, 2'h1, 21'h12, 32'h0000_CDEF, 32'h0),
            mk(1'h0, 2'h1, 21'h12, 32'h0, 32'h0000_CDEF),
            mk(1'h0, 2'h0, 21'h11, 32'h0, 32'h0000_00AB),
            mk(1'h1, 2'h3, 21'h10, 32'hFFFF_FFFF, 32'h0),
            mk(1'h0, 2'h2, 21'h10, 32'h0, 32'hCDEF_AB44),
            mk(1'h1, 2'h2, 21'h1F_FFFC, 32'h5A5A_0F0F, 32'h0),
            mk(1'h0, 2'h1, 21'h1F_FFFE, 32'h0, 32'h0000_5A5A),
            mk(1'h0, 2'h0, 21'h1F_FFFC, 32'h0, 32'h0000_000F)};
        repeat (3) @(posedge core_clk);
        #1;
        chk({4'h0, pins}, {4'h0, sramc_pkg::PINS_IDLE});
        chk({31'h0, data_oe_n}, 32'h1);
        rst = 1'b0;
        for (int i = 0; i < 11; i++) run(rows[i]);
        retention_req = 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (retention_active !== 1'b1 && n < 50);
        if (retention_active !== 1'b1) give_up();
        chk({28'h0, pins.lane_select_n}, 32'hF);
        retention_req = 1'b0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        if (req_ready !== 1'b1) give_up();
        chk({31'h0, n >= REC}, 32'h1);
        #1;
        rst = 1'b1;
        @(posedge core_clk);
        #1;
        rst = 1'b0;
        run(rows[7]);
        stop_test();
    end
endmodule : tb_async_sram_512k_x32_module
`default_nettype wire
